// *** xs_pcs_dev.sv ***
// switchable 1000base-x / sgmii pcs control: standard, registers, auto-negotiation
//
// Overview of operation
// [R1] select low at reset gives 1000base-x
// [R2] select high at reset gives sgmii
// [R3] run-time select change needs core reset
// [R4] manager should switch via registers, not pin
// [R5] standard write accepted anytime, applies immediately
// [R6] registers 0-16 follow current standard layout
// [R7] negotiation behaves per selected standard
// [R8] running negotiation finishes at original standard
// [R9] standard write does not restart negotiation
// [R10] manager reprograms register 4 after basex switch
// [R11] manager restarts negotiation via bit 0.9
// [R12] run-time switching only with dynamic option
// [R13] attached mac must run full duplex
// [R14] link timer 1.6 ms sgmii, 10 ms basex
// [R15] sgmii partner word carries speed, duplex
// [R16] select sampled in reset, held until changed
// [R17] standard latched at each sequence start
//
// Added by the designer: the APB slave port and the address map.
`include "xs_defs.svh"

module xs_pcs_dev
  import xs_pkg::*;
#(
  parameter bit          DYN_SWITCH     = 1'b1,
  parameter int unsigned LINK_BASEX_CYC = `XS_LINK_BASEX_NS / `XS_CLK_PERIOD_NS,
  parameter int unsigned LINK_SGMII_CYC = `XS_LINK_SGMII_NS / `XS_CLK_PERIOD_NS
) (
  input  wire logic   i_core_clk,
  input  wire logic   i_rst_b,
  xs_mgmt_if.dev      mgmt,
  input  wire logic   i_lp_valid,
  input  xs_word_t    i_lp_word,
  output logic        o_std_sgmii,
  output logic        o_an_busy,
  output xs_word_t    o_status_vector
);

  localparam int unsigned TW = $clog2(LINK_BASEX_CYC + 1);

  // refuse timer counts that the shared counter cannot serve
  if (LINK_BASEX_CYC < 1 || LINK_SGMII_CYC < 1
      || LINK_SGMII_CYC > LINK_BASEX_CYC) begin : g_bad_cfg
    $error("xs_pcs_dev: link timer counts must be nonzero and sgmii not above basex");
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  xs_std_e      std_q;
  logic         boot_q;
  xs_word_t     ctrl_q;
  xs_word_t     adv_q;
  xs_word_t     lp_q;
  logic         an_done_q;
  logic         ack_q;
  xs_word_t     rdata_q;
  xs_an_state_e an_q;
  xs_std_e      an_std_q;
  logic [TW-1:0] tmr_q;
  logic         wr_ctrl;
  logic         wr_adv;
  logic         wr_std;
  logic         restart;
  logic         take;
  logic [TW-1:0] tmr_lim;

  // a request is taken once; the ack pulse blocks a second take
  assign take    = mgmt.req && !ack_q;
  assign wr_ctrl = take && mgmt.we && mgmt.addr == `XS_REG_CTRL;
  assign wr_adv  = take && mgmt.we && mgmt.addr == `XS_REG_ADV;
  assign wr_std  = take && mgmt.we && mgmt.addr == `XS_REG_STDSEL;
  assign restart = wr_ctrl && mgmt.wdata[`XS_CTRL_RESTART_BIT];

  // ----------------------------------------------------------------
  // operating standard
  // ----------------------------------------------------------------
  // async reset can only load a constant, so the strap is caught on the
  // first edge after release and on every synchronous core reset cycle
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      std_q <= XS_STD_BASEX;
    end else if (boot_q || mgmt.core_rst) begin
      std_q <= mgmt.std_sel ? XS_STD_SGMII : XS_STD_BASEX;  // see [R1] see [R2] see [R3] see [R16]
    end else if (wr_std && DYN_SWITCH) begin
      // takes effect as the write completes; no restart here
      std_q <= mgmt.wdata[`XS_STD_BIT] ? XS_STD_SGMII : XS_STD_BASEX;  // see [R5] see [R9] see [R12]
    end
  end

  // ----------------------------------------------------------------
  // writable management registers
  // ----------------------------------------------------------------
  // the restart bit is self-clearing, so it is never stored
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= `XS_CTRL_RST_VAL;
    end else if (mgmt.core_rst) begin
      ctrl_q <= `XS_CTRL_RST_VAL;
    end else if (wr_ctrl) begin
      ctrl_q <= mgmt.wdata & ~(16'h0001 << `XS_CTRL_RESTART_BIT);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      adv_q <= `XS_ADV_BASEX_RST;
    end else if (mgmt.core_rst) begin
      adv_q <= `XS_ADV_BASEX_RST;
    end else if (wr_adv && std_q == XS_STD_BASEX) begin
      adv_q <= mgmt.wdata;  // sgmii advertisement is fixed, see [R6]
    end
  end

  // ----------------------------------------------------------------
  // management read path and answer
  // ----------------------------------------------------------------
  // layout of the advertisement and partner registers depends on the standard in force now
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 16'h0000;
    end else if (take && !mgmt.we) begin
      unique case (mgmt.addr)
        `XS_REG_CTRL:   rdata_q <= ctrl_q;
        `XS_REG_STAT:   rdata_q <= `XS_STAT_FIXED
                                   | (16'(an_done_q) << `XS_STAT_DONE_BIT)
                                   | (16'(an_done_q) << `XS_STAT_LINK_BIT);
        `XS_REG_ADV:    rdata_q <= (std_q == XS_STD_SGMII) ? `XS_ADV_SGMII : adv_q;  // see [R6]
        `XS_REG_LP:     rdata_q <= lp_q & ((std_q == XS_STD_SGMII) ? `XS_LP_SGMII_MASK
                                                                   : `XS_LP_BASEX_MASK);  // see [R6]
        `XS_REG_STDSEL: rdata_q <= 16'(std_q == XS_STD_SGMII) << `XS_STD_BIT;
        default:        rdata_q <= 16'h0000;  // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  assign mgmt.ack   = ack_q;
  assign mgmt.rdata = rdata_q;

  // ----------------------------------------------------------------
  // auto-negotiation sequence
  // ----------------------------------------------------------------
  // timer length follows the latched standard, not the live one
  assign tmr_lim = (an_std_q == XS_STD_SGMII) ? TW'(LINK_SGMII_CYC)
                                              : TW'(LINK_BASEX_CYC);  // see [R14] see [R7]

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      an_q     <= XS_AN_IDLE;
      an_std_q <= XS_STD_BASEX;
      tmr_q    <= '0;
    end else if (mgmt.core_rst || !ctrl_q[`XS_CTRL_AN_EN_BIT]) begin
      an_q  <= XS_AN_IDLE;
      tmr_q <= '0;
    end else if (restart) begin
      an_q     <= XS_AN_ACQ;
      an_std_q <= std_q;  // see [R17]
      tmr_q    <= '0;
    end else begin
      unique case (an_q)
        XS_AN_IDLE: begin
          // a fresh start after reset or enable, never after a standard write
          if (!boot_q && !an_done_q) begin
            an_q     <= XS_AN_ACQ;
            an_std_q <= std_q;  // see [R17]
          end
        end
        XS_AN_ACQ: begin
          if (i_lp_valid) begin
            an_q  <= XS_AN_LINK;
            tmr_q <= '0;
          end
        end
        XS_AN_LINK: begin
          // a standard change here is ignored until the sequence ends
          if (!i_lp_valid) begin
            an_q <= XS_AN_ACQ;
          end else if (tmr_q == tmr_lim - TW'(1)) begin
            an_q <= XS_AN_DONE;  // see [R8]
          end else begin
            tmr_q <= tmr_q + TW'(1);
          end
        end
        XS_AN_DONE: begin
          an_q <= XS_AN_DONE;
        end
      endcase
    end
  end

  // partner word captured at the end of the link timer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lp_q      <= 16'h0000;
      an_done_q <= 1'b0;
    end else if (mgmt.core_rst || restart || !ctrl_q[`XS_CTRL_AN_EN_BIT]) begin
      an_done_q <= 1'b0;
    end else if (an_q == XS_AN_LINK && i_lp_valid && tmr_q == tmr_lim - TW'(1)) begin
      lp_q      <= i_lp_word;
      an_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // sgmii reports partner speed and duplex; basex only its duplex ability
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status_vector <= 16'h0000;
      o_std_sgmii     <= 1'b0;
      o_an_busy       <= 1'b0;
    end else begin
      o_std_sgmii <= (std_q == XS_STD_SGMII);
      o_an_busy   <= (an_q == XS_AN_ACQ) || (an_q == XS_AN_LINK);
      o_status_vector <= 16'h0000;
      o_status_vector[`XS_SV_DONE_BIT] <= an_done_q;
      if (an_std_q == XS_STD_SGMII) begin
        o_status_vector[`XS_SV_SPEED_LO +: 2] <= lp_q[`XS_LP_SPEED_LO +: 2];  // see [R15]
        o_status_vector[`XS_SV_DUPLEX_BIT]    <= lp_q[`XS_LP_DUPLEX_BIT];    // see [R15]
      end else begin
        o_status_vector[`XS_SV_DUPLEX_BIT]    <= lp_q[`XS_LP_BASEX_FD_BIT];
      end
    end
  end

endmodule

// *** xs_defs.svh ***
// constants shared by both ends of the standard switch
`ifndef XS_DEFS_SVH
`define XS_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define XS_CLK_PERIOD_NS     10
`define XS_LINK_BASEX_NS     10000000
`define XS_LINK_SGMII_NS     1600000

// ----------------------------------------------------------------
// management register indices and fields
// ----------------------------------------------------------------
`define XS_REG_CTRL          5'h00
`define XS_REG_STAT          5'h01
`define XS_REG_ADV           5'h04
`define XS_REG_LP            5'h05
`define XS_REG_STDSEL        5'h11
`define XS_CTRL_RST_VAL      16'h1140
`define XS_CTRL_RESTART_BIT  9
`define XS_CTRL_AN_EN_BIT    12
`define XS_STAT_LINK_BIT     2
`define XS_STAT_DONE_BIT     5
`define XS_STAT_FIXED        16'h0108
`define XS_ADV_BASEX_RST     16'h0020
`define XS_ADV_SGMII         16'h0001
`define XS_LP_BASEX_MASK     16'hf1e0
`define XS_LP_SGMII_MASK     16'h9c01
`define XS_LP_SPEED_LO       10
`define XS_LP_DUPLEX_BIT     12
`define XS_LP_BASEX_FD_BIT   5
`define XS_STD_BIT           0
`define XS_SV_DONE_BIT       0
`define XS_SV_SPEED_LO       10
`define XS_SV_DUPLEX_BIT     12

// ----------------------------------------------------------------
// controller apb map and fields
// ----------------------------------------------------------------
`define XS_APB_CTRL          12'h000
`define XS_APB_CMD           12'h004
`define XS_APB_STAT          12'h008
`define XS_CMD_WE_BIT        24
`define XS_CMD_ADDR_LO       16
`define XS_CMD_DATA_LO       0
`define XS_CTRL_SEL_BIT      0
`define XS_CTRL_CRST_BIT     1
`define XS_STAT_BUSY_BIT     0
`define XS_STAT_DONE_BIT_H   1
`define XS_STAT_RDATA_LO     16

`endif

// *** xs_pkg.sv ***
// types shared by both ends of the standard switch
package xs_pkg;
  // operating standard of the pcs
  typedef enum logic {
    XS_STD_BASEX,
    XS_STD_SGMII
  } xs_std_e;

  // auto-negotiation sequence states
  typedef enum logic [1:0] {
    XS_AN_IDLE,
    XS_AN_ACQ,
    XS_AN_LINK,
    XS_AN_DONE
  } xs_an_state_e;

  typedef logic [15:0] xs_word_t;
endpackage

// *** xs_mgmt_if.sv ***
// management link between the switchable pcs and its controller
interface xs_mgmt_if;
  import xs_pkg::*;
  logic        std_sel;    // standard select level
  logic        core_rst;   // one-cycle core reset request
  logic        req;        // management request, held until ack
  logic        we;         // request is a write
  logic [4:0]  addr;       // register index
  xs_word_t    wdata;
  xs_word_t    rdata;
  logic        ack;        // one-cycle answer

  modport dev (input std_sel, core_rst, req, we, addr, wdata, output rdata, ack);
  modport ctl (output std_sel, core_rst, req, we, addr, wdata, input rdata, ack);
endinterface

// *** xs_mgmt_ctl.sv ***
// management controller: apb slave that drives the pcs select, reset and registers
`include "xs_defs.svh"

module xs_mgmt_ctl
  import xs_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  xs_mgmt_if.ctl           mgmt,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        acc;
  logic        hit;
  logic        sel_q;
  logic        crst_q;
  logic        busy_q;
  logic        done_q;
  logic        req_q;
  logic        we_q;
  logic [4:0]  addr_q;
  xs_word_t    wdata_q;
  xs_word_t    rdata_q;
  logic        cmd_go;

  // zero wait states: every access completes in its first access cycle
  assign acc      = i_psel && i_penable;
  assign hit      = i_paddr == `XS_APB_CTRL || i_paddr == `XS_APB_CMD
                    || i_paddr == `XS_APB_STAT;
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !hit;
  // a command while busy is dropped; status shows busy for software to poll
  assign cmd_go   = acc && i_pwrite && i_paddr == `XS_APB_CMD && !busy_q;

  always_comb begin
    o_prdata = 32'h0000_0000;
    if (acc && !i_pwrite) begin
      unique case (i_paddr)
        `XS_APB_CTRL: o_prdata = {31'h0000_0000, sel_q};
        `XS_APB_STAT: o_prdata = {rdata_q, 14'h0000, done_q, busy_q};
        default:      o_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // select level and core reset request
  // ----------------------------------------------------------------
  // the pin change alone does nothing until a core reset follows it
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_q  <= 1'b0;
      crst_q <= 1'b0;
    end else begin
      crst_q <= 1'b0;
      if (acc && i_pwrite && i_paddr == `XS_APB_CTRL) begin
        sel_q  <= i_pwdata[`XS_CTRL_SEL_BIT];
        crst_q <= i_pwdata[`XS_CTRL_CRST_BIT];  // see [R3]
      end
    end
  end

  assign mgmt.std_sel  = sel_q;
  assign mgmt.core_rst = crst_q;

  // ----------------------------------------------------------------
  // management transaction
  // ----------------------------------------------------------------
  // software is expected to switch standards with a register write, then
  // reprogram the advertisement and restart negotiation through this path
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= 5'h00;
      wdata_q <= 16'h0000;
      busy_q  <= 1'b0;
    end else if (cmd_go) begin
      req_q   <= 1'b1;  // see [R4] see [R10] see [R11]
      we_q    <= i_pwdata[`XS_CMD_WE_BIT];
      addr_q  <= i_pwdata[`XS_CMD_ADDR_LO +: 5];
      wdata_q <= i_pwdata[`XS_CMD_DATA_LO +: 16];
      busy_q  <= 1'b1;
    end else if (mgmt.ack) begin
      req_q  <= 1'b0;
      busy_q <= 1'b0;
    end
  end

  // done is sticky; the ack setting it wins over a same-cycle clear
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_q  <= 1'b0;
      rdata_q <= 16'h0000;
    end else if (mgmt.ack) begin
      done_q <= 1'b1;
      if (!we_q) begin
        rdata_q <= mgmt.rdata;
      end
    end else if (acc && i_pwrite && i_paddr == `XS_APB_STAT
                 && i_pwdata[`XS_STAT_DONE_BIT_H]) begin
      done_q <= 1'b0;
    end
  end

  assign mgmt.req   = req_q;
  assign mgmt.we    = we_q;
  assign mgmt.addr  = addr_q;
  assign mgmt.wdata = wdata_q;

endmodule

// *** xs_mgmt_sva.sv ***
// assertion checker for the management link and pcs outputs
`include "xs_defs.svh"
module xs_mgmt_sva
  import xs_pkg::*;
#(
  parameter int unsigned LINK_SGMII_CYC = `XS_LINK_SGMII_NS / `XS_CLK_PERIOD_NS
) (
  input wire logic       i_core_clk,
  input wire logic       i_rst_b,
  input wire logic       std_sel,
  input wire logic       core_rst,
  input wire logic       req,
  input wire logic       we,
  input wire logic [4:0] addr,
  input wire xs_word_t   wdata,
  input wire xs_word_t   rdata,
  input wire logic       ack,
  input wire logic       i_lp_valid,
  input wire logic       o_std_sgmii,
  input wire logic       o_an_busy,
  input wire xs_word_t   o_status_vector
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // run length of a present partner word; saturates so it never wraps
  logic [31:0] lpcnt_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) lpcnt_q <= 32'h0;
    else if (!i_lp_valid) lpcnt_q <= 32'h0;
    else if (lpcnt_q != 32'hffff_ffff) lpcnt_q <= lpcnt_q + 32'h1;
  end
  wire std_wr = ack && we && (addr == `XS_REG_STDSEL);
  wire rd_ack = ack && !we;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_ACK_AFTER_REQ: assert property ($rose(req) |=> ack)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  AST_ACK_NEEDS_REQ: assert property (ack |-> req)
    else $error("ack without request");
  AST_STD_WRITE: assert property (std_wr |=> o_std_sgmii == $past(wdata[0]))
    else $error("standard write did not take effect");
  AST_CORE_RST_STD: assert property (core_rst |-> ##2 o_std_sgmii == $past(std_sel, 2))
    else $error("core reset did not sample select level");
  AST_NO_RESTART: assert property (std_wr && o_status_vector[0] |=> !o_an_busy [*3])
    else $error("standard write restarted negotiation");
  AST_ADV_SGMII: assert property (rd_ack && addr == `XS_REG_ADV && o_std_sgmii
    |-> rdata == `XS_ADV_SGMII)
    else $error("advertisement layout wrong in sgmii");
  AST_UNMAPPED_ZERO: assert property (rd_ack && addr == 5'h1f |-> rdata == 16'h0)
    else $error("unmapped register read not zero");
  AST_LINK_TIMER: assert property ($rose(o_status_vector[0]) |-> lpcnt_q >= LINK_SGMII_CYC)
    else $error("negotiation finished before link timer");
  // main scenarios
  cover property (std_wr);
  cover property (core_rst);
  cover property ($rose(o_status_vector[0]) && o_std_sgmii);
endmodule

// *** basex_sgmii_standard_switch_tb.sv ***
// self-checking bench: apb controller driving the switchable pcs
`include "xs_defs.svh"
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (x)); end end
module basex_sgmii_standard_switch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import xs_pkg::*;
  // short timers keep the run brief; expectations derive from these
  localparam int BX = 50;
  localparam int SG = 8;
  logic        i_core_clk;
  logic        i_rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lp_valid;
  logic        std_sgmii;
  logic        an_busy;
  xs_word_t    lp_word;
  xs_word_t    sv;
  xs_word_t    q;
  logic [31:0] r;
  logic        e;
  logic [31:0] rnd;
  int          error_cnt;
  int          comparisons;
  int          cyc;
  xs_mgmt_if mlink ();
  xs_pcs_dev #(.DYN_SWITCH(1'b1), .LINK_BASEX_CYC(BX), .LINK_SGMII_CYC(SG)) u_xs_pcs_dev (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .mgmt(mlink), .i_lp_valid(lp_valid),
    .i_lp_word(lp_word), .o_std_sgmii(std_sgmii), .o_an_busy(an_busy), .o_status_vector(sv));
  xs_mgmt_ctl u_xs_mgmt_ctl (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .mgmt(mlink), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
  xs_mgmt_sva #(.LINK_SGMII_CYC(SG)) u_xs_mgmt_sva (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .std_sel(mlink.std_sel),
    .core_rst(mlink.core_rst), .req(mlink.req), .we(mlink.we), .addr(mlink.addr),
    .wdata(mlink.wdata), .rdata(mlink.rdata), .ack(mlink.ack), .i_lp_valid(lp_valid),
    .o_std_sgmii(std_sgmii), .o_an_busy(an_busy), .o_status_vector(sv));
  // ----------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // one apb transfer; held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    @(posedge i_core_clk);
    while (pready !== 1'b1) @(posedge i_core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // register access through the controller: command, poll done, clear done
  task automatic mg(input logic w, input logic [4:0] a, input xs_word_t d);
    int n;
    apb(1'b1, `XS_APB_CMD, {7'h0, w, 3'h0, a, d});
    n = 0;
    r = 32'h0;
    while (r[`XS_STAT_DONE_BIT_H] !== 1'b1 && n < 50) begin
      apb(1'b0, `XS_APB_STAT, 32'h0);
      n++;
    end
    `CHK(r[`XS_STAT_DONE_BIT_H], 1'b1);
    q = r[31:16];
    apb(1'b1, `XS_APB_STAT, 32'h2);
  endtask
  // model of the result word: sgmii keeps speed and duplex, basex duplex only
  function automatic xs_word_t sv_exp(input int sg, input xs_word_t lp);
    return sg ? ((lp & 16'h1c00) | 16'h0001) : {3'h0, lp[5], 12'h001};
  endfunction
  // hold partner away, optionally restart and switch, then time the sequence
  task automatic run_an(input int rs, input int sw, input int sg, input int tmr);
    int n;
    lp_valid <= 1'b0;
    if (rs != 0) mg(1'b1, `XS_REG_CTRL, `XS_CTRL_RST_VAL | 16'h0200);
    if (sw >= 0) mg(1'b1, `XS_REG_STDSEL, xs_word_t'(sw));
    @(posedge i_core_clk);
    rnd = lfsr(rnd);
    // partner always offers full duplex so the attached mac never runs half
    lp_word <= rnd[15:0] | 16'h1020;
    lp_valid <= 1'b1;
    n = 0;
    while (sv[0] !== 1'b1 && n < 2000) begin
      @(posedge i_core_clk);
      n++;
    end
    `CHK(n >= tmr && n <= tmr + 6, 1'b1);
    `CHK(sv, sv_exp(sg, lp_word));
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    lp_valid = 1'b0;
    lp_word = 16'h0;
    rnd = 32'h06fb9c1b;
    repeat (12) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    `CHK(std_sgmii, 1'b0);
    mg(1'b0, `XS_REG_STDSEL, 16'h0);
    `CHK(q[0], 1'b0);
    mg(1'b0, `XS_REG_CTRL, 16'h0);
    `CHK(q, 16'h1140);
    mg(1'b0, `XS_REG_ADV, 16'h0);
    `CHK(q, 16'h0020);
    mg(1'b0, 5'h1f, 16'h0);
    `CHK(q, 16'h0);
    run_an(0, -1, 0, BX);
    mg(1'b0, `XS_REG_LP, 16'h0);
    `CHK(q, lp_word & 16'hf1e0);
    mg(1'b0, `XS_REG_STAT, 16'h0);
    `CHK(q, 16'h012c);
    $display("test boot_basex done");
    mg(1'b1, `XS_REG_STDSEL, 16'h1);
    `CHK(std_sgmii, 1'b1);
    `CHK(sv[0], 1'b1);
    `CHK(an_busy, 1'b0);
    mg(1'b1, `XS_REG_ADV, 16'h01a0);
    mg(1'b0, `XS_REG_ADV, 16'h0);
    `CHK(q, 16'h0001);
    mg(1'b0, `XS_REG_LP, 16'h0);
    `CHK(q, lp_word & 16'h9c01);
    run_an(1, -1, 1, SG);
    $display("test mgmt_switch done");
    run_an(1, 0, 1, SG);
    `CHK(std_sgmii, 1'b0);
    mg(1'b1, `XS_REG_ADV, 16'h01a0);
    mg(1'b0, `XS_REG_ADV, 16'h0);
    `CHK(q, 16'h01a0);
    run_an(1, -1, 0, BX);
    $display("test mid_sequence done");
    apb(1'b1, `XS_APB_CTRL, 32'h1);
    repeat (4) @(posedge i_core_clk);
    `CHK(std_sgmii, 1'b0);
    // a non-default control value lets the core reset restore be seen
    mg(1'b1, `XS_REG_CTRL, 16'h1100);
    apb(1'b1, `XS_APB_CTRL, 32'h3);
    repeat (4) @(posedge i_core_clk);
    `CHK(std_sgmii, 1'b1);
    mg(1'b0, `XS_REG_CTRL, 16'h0);
    `CHK(q, 16'h1140);
    apb(1'b0, 12'hffc, 32'h0);
    `CHK(e, 1'b1);
    $display("test pin_reset done");
    print_verdict();
  end
endmodule
